//--- core/health_cmd_consts.vh
`ifndef HEALTH_CMD_CONSTS_VH
`define HEALTH_CMD_CONSTS_VH

// register byte offsets
`define OFS_FEATURES 8'h00
`define OFS_COUNT 8'h04
`define OFS_SECTOR 8'h08
`define OFS_CYL_LOW 8'h0C
`define OFS_CYL_HIGH 8'h10
`define OFS_COMMAND 8'h14
`define OFS_ERROR 8'h18
`define OFS_ALT_STATUS 8'h1C
`define OFS_DATA 8'h20
`define OFS_FEATURE_STATE 8'h24
`define OFS_SELFTEST_STATUS 8'h28

// command, subcommands, parameters
`define CMD_HEALTH 8'hB0
`define SUB_READ_VALUES 8'hD0
`define SUB_READ_THRESH 8'hD1
`define SUB_AUTOSAVE 8'hD2
`define SUB_SAVE 8'hD3
`define SUB_OFFLINE 8'hD4
`define SUB_ENABLE 8'hD8
`define SUB_DISABLE 8'hD9
`define SUB_RET_STATUS 8'hDA
`define SUB_AUTO_OFFLINE 8'hDB
`define CNT_OFF 8'h00
`define CNT_AUTOSAVE_ON 8'hF1
`define CNT_AUTO_OFFLINE_ON 8'hF8
`define OP_COLLECT 8'h00
`define OP_SHORT 8'h01
`define OP_EXTENDED 8'h02
`define OP_SELECTIVE 8'h04
`define OP_STOP 8'h7F
`define OP_CAP_SHORT 8'h81
`define OP_CAP_EXTENDED 8'h82
`define OP_CAP_SELECTIVE 8'h84
`define SIG_LOW 8'h4F
`define SIG_HIGH 8'hC2
`define FAIL_LOW 8'hF4
`define FAIL_HIGH 8'h2C

// status and error bits
`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_ABT 2

// self-test execution status byte
`define STB_PASS 8'h00
`define STB_ABORTED 8'h10
`define STB_FAILED 8'h70
`define STB_RUNNING 8'hF0
`define STB_OFFSET 9'h16B

// transfer and routine lengths in cycles
`define BLOCK_LAST 9'h1FF
`define COLLECT_CYC 32'h000007D0
`define SHORT_CYC 32'h000003E8
`define EXTENDED_CYC 32'h00000FA0
`define SELECTIVE_CYC 32'h00000BB8
`define AUTOSAVE_CYC 32'h00000FA0

`endif

//--- core/health_cmd_dispatch.v
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "health_cmd_consts.vh"

module health_cmd_dispatch (
    // clock and reset
    input wire CLK_IN,
    input wire RSTN_IN,
    // axi4-lite write address and data
    input wire [7:0] S_AXI_AWADDR_IN,
    input wire S_AXI_AWVALID_IN,
    output reg S_AXI_AWREADY_OUT,
    input wire [31:0] S_AXI_WDATA_IN,
    input wire [3:0] S_AXI_WSTRB_IN,
    input wire S_AXI_WVALID_IN,
    output reg S_AXI_WREADY_OUT,
    // axi4-lite write response
    output reg [1:0] S_AXI_BRESP_OUT,
    output reg S_AXI_BVALID_OUT,
    input wire S_AXI_BREADY_IN,
    // axi4-lite read
    input wire [7:0] S_AXI_ARADDR_IN,
    input wire S_AXI_ARVALID_IN,
    output reg S_AXI_ARREADY_OUT,
    output reg [31:0] S_AXI_RDATA_OUT,
    output reg [1:0] S_AXI_RRESP_OUT,
    output reg S_AXI_RVALID_OUT,
    input wire S_AXI_RREADY_IN,
    // attribute store, same clock
    output reg [8:0] ATTR_ADDR_OUT,
    output reg ATTR_THRESH_SEL_OUT,
    input wire [7:0] ATTR_DATA_IN,
    output reg ATTR_SAVE_OUT,
    input wire POWER_SAVE_REQ_IN,
    // non-volatile settings, same clock, sampled in reset
    input wire NV_HEALTH_EN_IN,
    input wire NV_AUTOSAVE_IN,
    input wire NV_AUTO_OFFLINE_IN,
    output reg HEALTH_EN_OUT,
    output reg AUTOSAVE_OUT,
    output reg AUTO_OFFLINE_OUT,
    // media results, asynchronous pins
    input wire TEST_FAIL_IN,
    input wire THRESH_EXCEEDED_IN,
    // completion
    output reg INTRQ_OUT,
    output reg OFFLINE_ACTIVE_OUT
);

localparam S_IDLE = 5'b00001;
localparam S_BUSY = 5'b00010;
localparam S_XFER = 5'b00100;
localparam S_CAPT = 5'b01000;
localparam S_DONE = 5'b10000;

reg [4:0] state_r;
reg [7:0] feat_r, count_r, sector_r, cyl_lo_r, cyl_hi_r, cmd_r;
reg [7:0] err_r, stb_r;
reg bsy_r, drq_r, errst_r;
reg [31:0] cap_cnt_r, off_cnt_r, save_cnt_r;
reg cap_kind_sel_r;
reg off_run_r, off_susp_r, off_test_r, kill_r, start_pend_r;
reg [31:0] start_len_r;
reg start_test_r;
reg [1:0] sync1_r, sync2_r, sync3_r, filt_r;
reg aw_held_r, w_held_r, rd_pend_r;
reg [7:0] awaddr_r;
reg [31:0] wdata_r;
reg wstrb0_r;

wire [7:0] status_w;
wire wr_fire;
wire cmd_go;
wire data_pop;
wire [7:0] byte_w;

assign status_w = {bsy_r, ~bsy_r, 1'b0, 1'b1, drq_r, 2'b00, errst_r};
assign wr_fire = aw_held_r && w_held_r && !S_AXI_BVALID_OUT;
assign cmd_go = wr_fire && wstrb0_r && awaddr_r == `OFS_COMMAND &&
                state_r == S_IDLE;
assign data_pop = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT &&
                  S_AXI_ARADDR_IN == `OFS_DATA && drq_r;
assign byte_w = (!ATTR_THRESH_SEL_OUT && ATTR_ADDR_OUT == `STB_OFFSET) ?
                stb_r : ATTR_DATA_IN;

// test result and threshold pins: three flops, accept when last two agree
always @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
        sync1_r <= 2'h0;
        sync2_r <= 2'h0;
        sync3_r <= 2'h0;
        filt_r <= 2'h0;
    end else begin
        sync1_r <= {THRESH_EXCEEDED_IN, TEST_FAIL_IN};
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        if (sync2_r[0] == sync3_r[0])
            filt_r[0] <= sync3_r[0];
        if (sync2_r[1] == sync3_r[1])
            filt_r[1] <= sync3_r[1];
    end
end

// axi4-lite slave; address and data taken in either order
always @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        awaddr_r <= 8'h00;
        wdata_r <= 32'h00000000;
        wstrb0_r <= 1'b0;
        S_AXI_AWREADY_OUT <= 1'b0;
        S_AXI_WREADY_OUT <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b0;
        S_AXI_BRESP_OUT <= 2'h0;
        S_AXI_ARREADY_OUT <= 1'b0;
        S_AXI_RVALID_OUT <= 1'b0;
        S_AXI_RRESP_OUT <= 2'h0;
        S_AXI_RDATA_OUT <= 32'h00000000;
        rd_pend_r <= 1'b0;
    end else begin
        S_AXI_AWREADY_OUT <= !aw_held_r && !S_AXI_AWREADY_OUT &&
                             !S_AXI_BVALID_OUT;
        S_AXI_WREADY_OUT <= !w_held_r && !S_AXI_WREADY_OUT &&
                            !S_AXI_BVALID_OUT;
        if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_held_r <= 1'b1;
            awaddr_r <= S_AXI_AWADDR_IN;
            S_AXI_AWREADY_OUT <= 1'b0;
        end
        if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_held_r <= 1'b1;
            wdata_r <= S_AXI_WDATA_IN;
            wstrb0_r <= S_AXI_WSTRB_IN[0];
            S_AXI_WREADY_OUT <= 1'b0;
        end
        if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= (awaddr_r <= `OFS_COMMAND &&
                                awaddr_r[1:0] == 2'b00) ? 2'h0 : 2'h2;
        end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
        end
        S_AXI_ARREADY_OUT <= !rd_pend_r && !S_AXI_ARREADY_OUT;
        if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            rd_pend_r <= 1'b1;
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RRESP_OUT <= 2'h0;
            case (S_AXI_ARADDR_IN)
                `OFS_FEATURES: S_AXI_RDATA_OUT <= {24'h0, feat_r};
                `OFS_COUNT: S_AXI_RDATA_OUT <= {24'h0, count_r};
                `OFS_SECTOR: S_AXI_RDATA_OUT <= {24'h0, sector_r};
                `OFS_CYL_LOW: S_AXI_RDATA_OUT <= {24'h0, cyl_lo_r};
                `OFS_CYL_HIGH: S_AXI_RDATA_OUT <= {24'h0, cyl_hi_r};
                `OFS_COMMAND: S_AXI_RDATA_OUT <= {24'h0, status_w};
                `OFS_ALT_STATUS: S_AXI_RDATA_OUT <= {24'h0, status_w};
                `OFS_ERROR: S_AXI_RDATA_OUT <= {24'h0, err_r};
                `OFS_DATA:
                    S_AXI_RDATA_OUT <= {24'h0, drq_r ? byte_w : 8'h00};
                `OFS_FEATURE_STATE:
                    S_AXI_RDATA_OUT <= {28'h0, off_run_r, AUTO_OFFLINE_OUT,
                                        AUTOSAVE_OUT, HEALTH_EN_OUT};
                `OFS_SELFTEST_STATUS: S_AXI_RDATA_OUT <= {24'h0, stb_r};
                default: begin
                    S_AXI_RDATA_OUT <= 32'h00000000;
                    S_AXI_RRESP_OUT <= 2'h2;
                end
            endcase
        end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            rd_pend_r <= 1'b0;
        end
    end
end

// command engine
always @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
        state_r <= S_IDLE;
        feat_r <= 8'h00;
        count_r <= 8'h00;
        sector_r <= 8'h00;
        cyl_lo_r <= 8'h00;
        cyl_hi_r <= 8'h00;
        cmd_r <= 8'h00;
        err_r <= 8'h00;
        stb_r <= `STB_PASS;
        bsy_r <= 1'b0;
        drq_r <= 1'b0;
        errst_r <= 1'b0;
        INTRQ_OUT <= 1'b0;
        ATTR_ADDR_OUT <= 9'h000;
        ATTR_THRESH_SEL_OUT <= 1'b0;
        ATTR_SAVE_OUT <= 1'b0;
        // settings come back from the non-volatile copy
        HEALTH_EN_OUT <= NV_HEALTH_EN_IN;
        AUTOSAVE_OUT <= NV_AUTOSAVE_IN;
        AUTO_OFFLINE_OUT <= NV_AUTO_OFFLINE_IN;
        cap_cnt_r <= 32'h0;
        cap_kind_sel_r <= 1'b0;
        off_cnt_r <= 32'h0;
        save_cnt_r <= 32'h0;
        off_run_r <= 1'b0;
        off_susp_r <= 1'b0;
        off_test_r <= 1'b0;
        kill_r <= 1'b0;
        start_pend_r <= 1'b0;
        start_len_r <= 32'h0;
        start_test_r <= 1'b0;
        OFFLINE_ACTIVE_OUT <= 1'b0;
    end else begin
        ATTR_SAVE_OUT <= 1'b0;
        OFFLINE_ACTIVE_OUT <= off_run_r && !off_susp_r;
        // periodic autosave; power events save regardless
        if (AUTOSAVE_OUT && HEALTH_EN_OUT && save_cnt_r != 32'h0)
            save_cnt_r <= save_cnt_r - 32'h1;
        else
            save_cnt_r <= `AUTOSAVE_CYC;
        if ((AUTOSAVE_OUT && HEALTH_EN_OUT && save_cnt_r == 32'h0) ||
            POWER_SAVE_REQ_IN)
            ATTR_SAVE_OUT <= 1'b1;
        // taskfile writes are ignored while a command is in progress
        if (wr_fire && wstrb0_r && state_r == S_IDLE) begin
            case (awaddr_r)
                `OFS_FEATURES: feat_r <= wdata_r[7:0];
                `OFS_COUNT: count_r <= wdata_r[7:0];
                `OFS_SECTOR: sector_r <= wdata_r[7:0];
                `OFS_CYL_LOW: cyl_lo_r <= wdata_r[7:0];
                `OFS_CYL_HIGH: cyl_hi_r <= wdata_r[7:0];
                default: begin
                end
            endcase
        end
        // status read acknowledges the interrupt; a new one wins
        if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT &&
            S_AXI_ARADDR_IN == `OFS_COMMAND)
            INTRQ_OUT <= 1'b0;
        // off-line routine progress
        if (off_run_r && !off_susp_r) begin
            if (off_cnt_r == 32'h0) begin
                off_run_r <= 1'b0;
                if (off_test_r)
                    stb_r <= filt_r[0] ? `STB_FAILED : `STB_PASS;
            end else begin
                off_cnt_r <= off_cnt_r - 32'h1;
            end
        end
        case (state_r)
            S_IDLE: begin
                if (cmd_go) begin
                    cmd_r <= wdata_r[7:0];
                    bsy_r <= 1'b1;
                    errst_r <= 1'b0;
                    err_r <= 8'h00;
                    kill_r <= 1'b0;
                    off_susp_r <= off_run_r;
                    state_r <= S_BUSY;
                end
            end
            S_BUSY: begin
                bsy_r <= 1'b0;
                state_r <= S_DONE;
                if (cmd_r != `CMD_HEALTH || cyl_lo_r != `SIG_LOW ||
                    cyl_hi_r != `SIG_HIGH ||
                    (!HEALTH_EN_OUT && feat_r != `SUB_ENABLE)) begin
                    errst_r <= 1'b1;
                    err_r[`ER_ABT] <= 1'b1;
                end else begin
                    case (feat_r)
                        `SUB_READ_VALUES, `SUB_READ_THRESH: begin
                            ATTR_THRESH_SEL_OUT <= feat_r[0];
                            ATTR_ADDR_OUT <= 9'h000;
                            drq_r <= 1'b1;
                            state_r <= S_XFER;
                        end
                        `SUB_AUTOSAVE: begin
                            if (count_r == `CNT_OFF)
                                AUTOSAVE_OUT <= 1'b0;
                            else if (count_r == `CNT_AUTOSAVE_ON)
                                AUTOSAVE_OUT <= 1'b1;
                            else begin
                                errst_r <= 1'b1;
                                err_r[`ER_ABT] <= 1'b1;
                            end
                        end
                        `SUB_SAVE: ATTR_SAVE_OUT <= 1'b1;
                        `SUB_OFFLINE: begin
                            kill_r <= 1'b1;
                            case (sector_r)
                                `OP_COLLECT, `OP_SHORT, `OP_EXTENDED,
                                `OP_SELECTIVE: begin
                                    start_pend_r <= 1'b1;
                                    start_test_r <= sector_r != `OP_COLLECT;
                                    start_len_r <=
                                        sector_r == `OP_COLLECT ?
                                        `COLLECT_CYC :
                                        sector_r == `OP_SHORT ? `SHORT_CYC :
                                        sector_r == `OP_EXTENDED ?
                                        `EXTENDED_CYC : `SELECTIVE_CYC;
                                end
                                `OP_STOP: begin
                                end
                                `OP_CAP_SHORT, `OP_CAP_EXTENDED,
                                `OP_CAP_SELECTIVE: begin
                                    bsy_r <= 1'b1;
                                    stb_r <= `STB_RUNNING;
                                    cap_kind_sel_r <= 1'b1;
                                    cap_cnt_r <=
                                        sector_r == `OP_CAP_SHORT ?
                                        `SHORT_CYC :
                                        sector_r == `OP_CAP_EXTENDED ?
                                        `EXTENDED_CYC : `SELECTIVE_CYC;
                                    state_r <= S_CAPT;
                                end
                                default: begin
                                    kill_r <= 1'b0;
                                    errst_r <= 1'b1;
                                    err_r[`ER_ABT] <= 1'b1;
                                end
                            endcase
                        end
                        `SUB_ENABLE: begin
                            HEALTH_EN_OUT <= 1'b1;
                            ATTR_SAVE_OUT <= 1'b1;
                        end
                        `SUB_DISABLE: begin
                            HEALTH_EN_OUT <= 1'b0;
                            AUTOSAVE_OUT <= 1'b0;
                            ATTR_SAVE_OUT <= 1'b1;
                            kill_r <= 1'b1;
                        end
                        `SUB_RET_STATUS: begin
                            cyl_lo_r <= filt_r[1] ? `FAIL_LOW : `SIG_LOW;
                            cyl_hi_r <= filt_r[1] ? `FAIL_HIGH : `SIG_HIGH;
                        end
                        `SUB_AUTO_OFFLINE: begin
                            if (count_r == `CNT_OFF)
                                AUTO_OFFLINE_OUT <= 1'b0;
                            else if (count_r == `CNT_AUTO_OFFLINE_ON)
                                AUTO_OFFLINE_OUT <= 1'b1;
                            else begin
                                errst_r <= 1'b1;
                                err_r[`ER_ABT] <= 1'b1;
                            end
                        end
                        default: begin
                            errst_r <= 1'b1;
                            err_r[`ER_ABT] <= 1'b1;
                        end
                    endcase
                end
            end
            S_XFER: begin
                if (data_pop) begin
                    ATTR_ADDR_OUT <= ATTR_ADDR_OUT + 9'h001;
                    if (ATTR_ADDR_OUT == `BLOCK_LAST) begin
                        drq_r <= 1'b0;
                        state_r <= S_DONE;
                    end
                end
            end
            S_CAPT: begin
                // busy holds for the whole captive run
                if (cap_cnt_r == 32'h0) begin
                    bsy_r <= 1'b0;
                    cap_kind_sel_r <= 1'b0;
                    state_r <= S_DONE;
                    if (filt_r[0]) begin
                        stb_r <= `STB_FAILED;
                        errst_r <= 1'b1;
                        err_r[`ER_ABT] <= 1'b1;
                        cyl_lo_r <= `FAIL_LOW;
                        cyl_hi_r <= `FAIL_HIGH;
                    end else begin
                        stb_r <= `STB_PASS;
                    end
                end else begin
                    cap_cnt_r <= cap_cnt_r - 32'h1;
                end
            end
            S_DONE: begin
                // completion first, routine afterwards
                INTRQ_OUT <= 1'b1;
                state_r <= S_IDLE;
                off_susp_r <= 1'b0;
                if (off_susp_r && kill_r) begin
                    off_run_r <= 1'b0;
                    if (off_test_r)
                        stb_r <= `STB_ABORTED;
                end
                if (start_pend_r) begin
                    start_pend_r <= 1'b0;
                    off_run_r <= 1'b1;
                    off_cnt_r <= start_len_r;
                    off_test_r <= start_test_r;
                    if (start_test_r)
                        stb_r <= `STB_RUNNING;
                end
            end
            default: state_r <= S_IDLE;
        endcase
    end
end

endmodule // health_cmd_dispatch

//--- verification/attr_store_model.sv
`timescale 1ns/1ps
module attr_store_model (
    // byte lookup
    input wire [8:0] addr_in,
    input wire thresh_sel_in,
    output wire [7:0] data_out
);
    // differs per byte and per block, so a wrong index shows at once
    assign data_out =
        addr_in[7:0] ^ {thresh_sel_in, addr_in[8], 6'h15};
endmodule // attr_store_model

//--- verification/health_cmd_checker.sv
`timescale 1ns/1ps
module health_cmd_checker (
    // bus and events
    input wire CLK_IN, input wire RSTN_IN,
    input wire [7:0] S_AXI_AWADDR_IN, input wire S_AXI_AWVALID_IN,
    input wire S_AXI_AWREADY_OUT, input wire S_AXI_WVALID_IN,
    input wire S_AXI_WREADY_OUT, input wire S_AXI_BVALID_OUT,
    input wire S_AXI_BREADY_IN, input wire S_AXI_ARVALID_IN,
    input wire S_AXI_ARREADY_OUT, input wire S_AXI_RVALID_OUT,
    input wire ATTR_SAVE_OUT, input wire POWER_SAVE_REQ_IN,
    input wire AUTOSAVE_OUT, input wire INTRQ_OUT,
    input wire OFFLINE_ACTIVE_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    sequence wr_taken;
        S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN
            && S_AXI_WREADY_OUT;
    endsequence
    sequence cmd_in_routine;
        wr_taken ##0 (S_AXI_AWADDR_IN == 8'h14 && OFFLINE_ACTIVE_OUT);
    endsequence
    // address and data are held one edge before the response is launched
    write_resp_a: assert property (
        wr_taken |=> ##1 S_AXI_BVALID_OUT)
        else $error("no write response");
    bresp_hold_a: assert property (
        S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
        else $error("write response dropped");
    read_resp_a: assert property (
        S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
        else $error("no read response");
    power_save_a: assert property (
        POWER_SAVE_REQ_IN |=> ATTR_SAVE_OUT)
        else $error("power save not issued");
    autosave_done_a: assert property (
        $changed(AUTOSAVE_OUT) |=> INTRQ_OUT)
        else $error("autosave change without completion");
    offline_first_a: assert property (
        $rose(OFFLINE_ACTIVE_OUT) |->
        INTRQ_OUT || $past(INTRQ_OUT) || $past(INTRQ_OUT, 2))
        else $error("routine ran before completion");
    offline_yield_a: assert property (
        cmd_in_routine |-> ##[1:8] !OFFLINE_ACTIVE_OUT)
        else $error("routine not suspended");
    intrq_hold_a: assert property (
        INTRQ_OUT && !S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT &&
        !$past(S_AXI_RVALID_OUT) |=> INTRQ_OUT)
        else $error("interrupt lost");
endmodule // health_cmd_checker

//--- verification/smart_command_dispatch_tb.sv
`timescale 1ns/1ps
module smart_command_dispatch_tb;
    reg clk = 1'h0, rst_n = 1'h0, pwr = 1'h0, tfail = 1'h0, thr = 1'h0;
    reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, nv_as = 1'h0;
    reg arvalid = 1'h0, rready = 1'h0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00, v, stb;
    reg [31:0] wdata = 32'h0;
    reg [1:0] rr, br;
    wire awready, wready, bvalid, arready, rvalid, sel, save, intrq, act;
    wire [1:0] rresp, bresp;
    wire [31:0] rdata;
    wire [8:0] aaddr;
    wire [7:0] adata;
    integer errors = 0, n_compared = 0, saves = 0, i, k;
    always #2 clk = ~clk;
    always @(posedge clk) if (save) saves <= saves + 1;
    health_cmd_dispatch DUT (.CLK_IN(clk), .RSTN_IN(rst_n),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
        .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .ATTR_ADDR_OUT(aaddr),
        .ATTR_THRESH_SEL_OUT(sel), .ATTR_DATA_IN(adata),
        .ATTR_SAVE_OUT(save), .POWER_SAVE_REQ_IN(pwr),
        .NV_HEALTH_EN_IN(1'h1), .NV_AUTOSAVE_IN(nv_as),
        .NV_AUTO_OFFLINE_IN(1'h0), .HEALTH_EN_OUT(), .AUTOSAVE_OUT(),
        .AUTO_OFFLINE_OUT(), .TEST_FAIL_IN(tfail),
        .THRESH_EXCEEDED_IN(thr), .INTRQ_OUT(intrq),
        .OFFLINE_ACTIVE_OUT(act));
    attr_store_model model (.addr_in(aaddr), .thresh_sel_in(sel),
        .data_out(adata));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("Error %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("errors %0d compared %0d", errors, n_compared);
            if (errors == 0 && n_compared > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task hang;
        begin
            errors = errors + 1;
            print_verdict;
        end
    endtask
    // each channel released only at its own handshake edge
    task wr(input [7:0] a, input [7:0] d);
        integer n;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            for (n = 0; n < 99; n = n + 1) begin
                @(posedge clk);
                if (awready && awvalid) awvalid <= 1'h0;
                if (wready && wvalid) wvalid <= 1'h0;
                if (bvalid && bready) begin
                    bready <= 1'h0;
                    br = bresp;
                    n = 500;
                end
            end
            if (n < 500) hang;
        end
    endtask
    task rd(input [7:0] a);
        integer n;
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            for (n = 0; n < 99; n = n + 1) begin
                @(posedge clk);
                if (arready && arvalid) arvalid <= 1'h0;
                if (rvalid && rready) begin
                    rready <= 1'h0;
                    v = rdata[7:0];
                    rr = rresp;
                    n = 500;
                end
            end
            if (n < 500) hang;
        end
    endtask
    task cmd(input [7:0] f, c, s, lo);
        begin
            wr(8'h00, f);
            wr(8'h04, c);
            wr(8'h08, s);
            wr(8'h0C, lo);
            wr(8'h10, 8'hC2);
            wr(8'h14, 8'hB0);
        end
    endtask
    task fin(input [7:0] es, ee);
        integer n;
        begin
            for (n = 0; n < 6000 && intrq !== 1'h1; n = n + 1) @(posedge clk);
            if (n == 6000) hang;
            rd(8'h14);
            chk(v, es);
            rd(8'h18);
            chk(v, ee);
        end
    endtask
    task run(input [7:0] f, c, s, lo, es, ee);
        begin
            cmd(f, c, s, lo);
            fin(es, ee);
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        rd(8'h14);
        chk(v, 8'h50);
        rd(8'h30);
        chk(rr, 2'h2);
        wr(8'h18, 8'h00);
        chk(br, 2'h2);
        run(8'hD2, 8'hF1, 8'h00, 8'h4F, 8'h50, 8'h00);
        chk(br, 2'h0);
        rd(8'h24);
        chk(v, 8'h03);
        run(8'hD2, 8'h05, 8'h00, 8'h4F, 8'h51, 8'h04);
        rd(8'h24);
        chk(v, 8'h03);
        run(8'hD2, 8'h00, 8'h00, 8'h4F, 8'h50, 8'h00);
        rd(8'h24);
        chk(v, 8'h01);
        k = saves;
        run(8'hD3, 8'h00, 8'h00, 8'h4F, 8'h50, 8'h00);
        chk(saves, k + 1);
        pwr <= 1'h1;
        @(posedge clk);
        pwr <= 1'h0;
        repeat (2) @(posedge clk);
        chk(saves, k + 2);
        run(8'hD3, 8'h00, 8'h00, 8'h00, 8'h51, 8'h04);
        for (i = 0; i < 8; i = i + 1)
            if (i < 3 || i == 7)
                run(8'hD5 + i[7:0], 8'h01, 8'h00, 8'h4F, 8'h51,
                    8'h04);
        for (k = 1; k >= 0; k = k - 1) begin
            thr <= k[0];
            run(8'hDA, 8'h00, 8'h00, 8'h4F, 8'h50, 8'h00);
            rd(8'h0C);
            chk(v, k ? 8'hF4 : 8'h4F);
        end
        for (k = 0; k < 2; k = k + 1) begin
            rd(8'h28);
            stb = v;
            v = 8'h00;
            cmd(8'hD0 + k[7:0], 8'h00, 8'h00, 8'h4F);
            for (i = 0; i < 99 && v[3] !== 1'h1; i = i + 1) rd(8'h14);
            if (i == 99) hang;
            for (i = 0; i < 512; i = i + 1) begin
                rd(8'h20);
                chk(v, (k == 0 && i == 9'h16B) ? stb :
                    i[7:0] ^ {k[0], i[8], 6'h15});
            end
            fin(8'h50, 8'h00);
        end
        for (i = 0; i < 3; i = i + 1) begin
            tfail <= (i == 2);
            run(8'hD4, 8'h00, 8'h81 + i[7:0] + (i[7:0] >> 1), 8'h4F,
                {7'h28, i == 2},
                {5'h0, i == 2, 2'h0});
            rd(8'h28);
            chk(v, i == 2 ? 8'h70 : 8'h00);
        end
        rd(8'h10);
        chk(v, 8'h2C);
        tfail <= 1'h0;
        for (i = 0; i < 4; i = i + 1) begin
            run(8'hD4, 8'h00, i[7:0] + {7'h0, i == 3}, 8'h4F, 8'h50,
                8'h00);
            chk(act, 1'h1);
        end
        run(8'hD3, 8'h00, 8'h00, 8'h4F, 8'h50, 8'h00);
        chk(act, 1'h1);
        run(8'hD4, 8'h00, 8'h7F, 8'h4F, 8'h50, 8'h00);
        chk(act, 1'h0);
        rd(8'h28);
        chk(v, 8'h10);
        run(8'hD2, 8'hF1, 8'h00, 8'h4F, 8'h50, 8'h00);
        run(8'hD4, 8'h00, 8'h00, 8'h4F, 8'h50, 8'h00);
        run(8'hD9, 8'h00, 8'h00, 8'h4F, 8'h50, 8'h00);
        chk(act, 1'h0);
        rd(8'h24);
        chk(v, 8'h00);
        run(8'hD2, 8'hF1, 8'h00, 8'h4F, 8'h51, 8'h04);
        run(8'hD9, 8'h00, 8'h00, 8'h4F, 8'h51, 8'h04);
        run(8'hD8, 8'h00, 8'h00, 8'h4F, 8'h50, 8'h00);
        run(8'hDB, 8'hF8, 8'h00, 8'h4F, 8'h50, 8'h00);
        rd(8'h24);
        chk(v, 8'h05);
        // second reset mid-run: settings come back from the stored copy
        nv_as <= 1'h1;
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        rd(8'h24);
        chk(v, 8'h03);
        rd(8'h14);
        chk(v, 8'h50);
        print_verdict;
    end
endmodule // smart_command_dispatch_tb
bind health_cmd_dispatch health_cmd_checker chk_u (.*);
